// File: drp_register_port.v
// serial register port of the display controller with staged register updates
`timescale 1ns/1ps
`include "drp_map.vh"

module drp_register_port #(
   parameter [15:0] FW_VERSION = 16'h0001, // arbitrary value
   parameter [21:0] STALL_CYC = `DRP_STALL_CYC
)(
   input wire clock,
   input wire rst,
   input wire scl_in,
   output wire scl_out,
   output reg scl_oe,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   input wire ctrl_busy,
   input wire err_state,
   input wire line_start,
   input wire field_start,
   output wire [`DRP_NUM_REGS*16-1:0] active_regs
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_DEV = 4'h1;
   localparam [3:0] ST_SUB = 4'h2;
   localparam [3:0] ST_AHI = 4'h3;
   localparam [3:0] ST_ALO = 4'h4;
   localparam [3:0] ST_WHI = 4'h5;
   localparam [3:0] ST_WLO = 4'h6;
   localparam [3:0] ST_RHI = 4'h7;
   localparam [3:0] ST_RLO = 4'h8;
   localparam [3:0] ST_WAIT = 4'h9;

   // both lines are open drain: we only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // ----------------------------------------
   // pin synchronisers and edge detection
   // ----------------------------------------
   reg scl_m, scl_s, scl_d;
   reg sda_m, sda_s, sda_d;
   wire scl_rise;
   wire scl_fall;
   wire bus_start;
   wire bus_stop;

   // three flops per pin, edges compare the second and third stages
   always @(posedge clock) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign bus_start = scl_s & scl_d & sda_d & ~sda_s; // [RULE2]
   assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------
   // address lookup
   // ----------------------------------------
   // returns {hit, index}; anything not in the bank misses
   function [6:0] drp_lookup;
      input [15:0] a;
      begin
         case (a)
            `DRP_A_FIRMWARE_VERSION: drp_lookup = {1'b1, 6'h00};
            `DRP_A_BEAM_CURRENT_CTRL: drp_lookup = {1'b1, 6'h01};
            `DRP_A_RED_CUTOFF_LEVEL: drp_lookup = {1'b1, 6'h02};
            `DRP_A_GREEN_CUTOFF_LEVEL: drp_lookup = {1'b1, 6'h03};
            `DRP_A_BLUE_CUTOFF_LEVEL: drp_lookup = {1'b1, 6'h04};
            `DRP_A_RED_WHITE_DRIVE: drp_lookup = {1'b1, 6'h05};
            `DRP_A_GREEN_WHITE_DRIVE: drp_lookup = {1'b1, 6'h06};
            `DRP_A_BLUE_WHITE_DRIVE: drp_lookup = {1'b1, 6'h07};
            `DRP_A_ANALOG_MEAS_CTRL: drp_lookup = {1'b1, 6'h08};
            `DRP_A_RED_CHANNEL_CTRL: drp_lookup = {1'b1, 6'h09};
            `DRP_A_GREEN_CHANNEL_CTRL: drp_lookup = {1'b1, 6'h0a};
            `DRP_A_BLUE_CHANNEL_CTRL: drp_lookup = {1'b1, 6'h0b};
            `DRP_A_SCALER_MODE_SELECT: drp_lookup = {1'b1, 6'h0c};
            `DRP_A_LINE_FIFO_ACTIVE_LENGTH: drp_lookup = {1'b1, 6'h0d};
            `DRP_A_COMPRESS_SCALER_COEFF: drp_lookup = {1'b1, 6'h0e};
            `DRP_A_EXPAND_SCALER_COEFF: drp_lookup = {1'b1, 6'h0f};
            `DRP_A_NONLINEAR_SCALING_COEFF: drp_lookup = {1'b1, 6'h10};
            `DRP_A_SCALER_A_WINDOW_1: drp_lookup = {1'b1, 6'h11};
            `DRP_A_SCALER_A_WINDOW_2: drp_lookup = {1'b1, 6'h12};
            `DRP_A_SCALER_A_WINDOW_3: drp_lookup = {1'b1, 6'h13};
            `DRP_A_SCALER_A_WINDOW_4: drp_lookup = {1'b1, 6'h14};
            `DRP_A_SCALER_A_WINDOW_5: drp_lookup = {1'b1, 6'h15};
            `DRP_A_SCALER_B_WINDOW_1: drp_lookup = {1'b1, 6'h16};
            `DRP_A_SCALER_B_WINDOW_2: drp_lookup = {1'b1, 6'h17};
            `DRP_A_SCALER_B_WINDOW_3: drp_lookup = {1'b1, 6'h18};
            `DRP_A_SCALER_B_WINDOW_4: drp_lookup = {1'b1, 6'h19};
            `DRP_A_SCALER_B_WINDOW_5: drp_lookup = {1'b1, 6'h1a};
            `DRP_A_LUMA_TRANSIENT_CTRL: drp_lookup = {1'b1, 6'h1b};
            `DRP_A_LUMA_FILTER_SELECT: drp_lookup = {1'b1, 6'h1c};
            `DRP_A_LUMA_TRANSIENT_MIX_A: drp_lookup = {1'b1, 6'h1d};
            `DRP_A_BLUE_TONE_CURVE: drp_lookup = {1'b1, 6'h1e};
            `DRP_A_LUMA_TRANSIENT_MIX_B: drp_lookup = {1'b1, 6'h1f};
            `DRP_A_GREEN_TONE_CURVE: drp_lookup = {1'b1, 6'h20};
            `DRP_A_PICTURE_FRAME_GEN_CTRL: drp_lookup = {1'b1, 6'h21};
            `DRP_A_RED_TONE_CURVE: drp_lookup = {1'b1, 6'h22};
            `DRP_A_PEAKING_BAND_CTRL: drp_lookup = {1'b1, 6'h23};
            `DRP_A_BRIGHTNESS_MODE: drp_lookup = {1'b1, 6'h24};
            `DRP_A_VELOCITY_MOD_CTRL_B: drp_lookup = {1'b1, 6'h25};
            `DRP_A_TRANSIENT_LIMIT: drp_lookup = {1'b1, 6'h26};
            `DRP_A_VELOCITY_MOD_LIMIT: drp_lookup = {1'b1, 6'h27};
            `DRP_A_VERTICAL_BLANK_STOP: drp_lookup = {1'b1, 6'h28};
            `DRP_A_VERTICAL_BLANK_START: drp_lookup = {1'b1, 6'h29};
            `DRP_A_VELOCITY_MOD_CTRL_A: drp_lookup = {1'b1, 6'h2a};
            `DRP_A_FRAME_GEN_VERTICAL_END: drp_lookup = {1'b1, 6'h2b};
            `DRP_A_PEAKING_CTRL_A: drp_lookup = {1'b1, 6'h2c};
            `DRP_A_CHROMA_TRANSIENT_CTRL: drp_lookup = {1'b1, 6'h2d};
            `DRP_A_FRAME_GEN_VERTICAL_BEGIN: drp_lookup = {1'b1, 6'h2e};
            `DRP_A_PEAKING_CTRL_B: drp_lookup = {1'b1, 6'h2f};
            `DRP_A_DEFLECTION_PARAM_B: drp_lookup = {1'b1, `DRP_IDX_HORZ_B};
            `DRP_A_DEFLECTION_PARAM_C: drp_lookup = {1'b1, `DRP_IDX_HORZ_C};
            default: drp_lookup = 7'h00;
         endcase
      end
   endfunction

   // ----------------------------------------
   // protocol engine
   // ----------------------------------------
   reg [3:0] state;
   reg [3:0] bitcnt;
   reg [7:0] shreg;
   reg [7:0] tx_sh;
   reg ack_phase;
   reg drove_ack;
   reg mack;
   reg sub_read;
   reg rd_ready;
   reg [15:0] addr;
   reg [7:0] wd_hi;
   reg [15:0] rdata;
   reg wr_en;
   reg [5:0] wr_idx;
   reg [15:0] wr_data;
   reg [21:0] stall_cnt;
   wire [`DRP_NUM_REGS*16-1:0] pend_flat;
   wire [6:0] hit;
   wire [15:0] full_addr;
   wire ack_ok;
   wire [6:0] wr_hit;

   assign full_addr = {addr[15:8], shreg}; // [RULE14]
   assign hit = drp_lookup(full_addr); // [RULE14]
   assign ack_ok = ~err_state; // [RULE5]
   assign wr_hit = drp_lookup(addr); // [RULE14]

   // one process owns all bus-facing state; edges come from the synced pins
   always @(posedge clock) begin
      if (rst) begin
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         tx_sh <= 8'h00;
         ack_phase <= 1'b0;
         drove_ack <= 1'b0;
         mack <= 1'b1;
         sub_read <= 1'b0;
         rd_ready <= 1'b0;
         addr <= 16'h0000;
         wd_hi <= 8'h00;
         rdata <= 16'h0000;
         wr_en <= 1'b0;
         wr_idx <= 6'h00;
         wr_data <= 16'h0000;
         sda_oe <= 1'b0;
         scl_oe <= 1'b0;
         stall_cnt <= 22'h000000;
      end else begin
         wr_en <= 1'b0;
         // stretching: release when controller frees up or the bound runs out
         if (scl_oe) begin
            if (!ctrl_busy || stall_cnt == STALL_CYC - 22'h000001) begin
               scl_oe <= 1'b0; // [RULE11]
            end
            stall_cnt <= stall_cnt + 22'h000001;
         end
         if (bus_start) begin
            // a repeated start keeps rd_ready so the data phase can follow
            state <= ST_DEV; // [RULE10]
            bitcnt <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state <= ST_IDLE;
            rd_ready <= 1'b0;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
         end else if (state == ST_RHI || state == ST_RLO) begin
            // transmit side: bits change on the falling clock
            if (ack_phase && scl_rise) begin
               mack <= sda_s;
            end else if (scl_fall && ack_phase) begin
               ack_phase <= 1'b0;
               drove_ack <= 1'b0;
               if (drove_ack) begin
                  // our own ack of the read address closes: high byte starts here
                  sda_oe <= ~rdata[15]; // [RULE10]
                  tx_sh <= {rdata[14:8], 1'b0};
                  bitcnt <= 4'h1;
               end else if (state == ST_RHI && !mack) begin
                  state <= ST_RLO; // [RULE10]
                  sda_oe <= ~rdata[7];
                  tx_sh <= {rdata[6:0], 1'b0};
                  bitcnt <= 4'h1;
               end else begin
                  state <= ST_WAIT; // [RULE4]
               end
            end else if (scl_fall && bitcnt == 4'h8) begin
               sda_oe <= 1'b0;
               ack_phase <= 1'b1;
            end else if (scl_fall) begin
               sda_oe <= ~tx_sh[7];
               tx_sh <= {tx_sh[6:0], 1'b0};
               bitcnt <= bitcnt + 4'h1;
            end
         end else if (state != ST_IDLE && state != ST_WAIT) begin
            // receive side: sample on rise, decide after the eighth bit
            if (scl_rise && !ack_phase) begin
               shreg <= {shreg[6:0], sda_s};
               bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && ack_phase) begin
               ack_phase <= 1'b0;
               bitcnt <= 4'h0;
               sda_oe <= 1'b0;
               if (drove_ack && ctrl_busy) begin
                  scl_oe <= 1'b1; // [RULE11]
                  stall_cnt <= 22'h000000;
               end
            end else if (scl_fall && bitcnt == 4'h8) begin
               ack_phase <= 1'b1;
               drove_ack <= 1'b0;
               case (state)
                  ST_DEV: begin
                     if (shreg[7:1] != `DRP_DEV_ADDR) begin
                        state <= ST_WAIT;
                     end else if (!ack_ok) begin
                        state <= ST_WAIT; // [RULE5]
                     end else if (!shreg[0]) begin
                        sda_oe <= 1'b1; // [RULE1] [RULE3]
                        drove_ack <= 1'b1;
                        rd_ready <= 1'b0;
                        state <= ST_SUB;
                     end else if (rd_ready) begin
                        sda_oe <= 1'b1; // [RULE10]
                        drove_ack <= 1'b1;
                        state <= ST_RHI;
                     end else begin
                        state <= ST_WAIT;
                     end
                  end
                  ST_SUB: begin
                     if (ack_ok && (shreg == `DRP_SUB_READ || shreg == `DRP_SUB_WRITE)) begin
                        sub_read <= (shreg == `DRP_SUB_READ); // [RULE13]
                        sda_oe <= 1'b1; // [RULE1] [RULE3]
                        drove_ack <= 1'b1;
                        state <= ST_AHI;
                     end else begin
                        state <= ST_WAIT; // [RULE5]
                     end
                  end
                  ST_AHI: begin
                     addr[15:8] <= shreg; // [RULE14]
                     sda_oe <= ack_ok; // [RULE3] [RULE5]
                     drove_ack <= ack_ok;
                     state <= ack_ok ? ST_ALO : ST_WAIT;
                  end
                  ST_ALO: begin
                     addr[7:0] <= shreg; // [RULE14]
                     sda_oe <= ack_ok; // [RULE3] [RULE5]
                     drove_ack <= ack_ok;
                     // unmapped addresses read back as zero
                     rdata <= hit[6] ? pend_flat[{hit[5:0], 4'h0} +: 16] : 16'h0000; // [RULE6] [RULE12]
                     rd_ready <= sub_read & ack_ok;
                     if (!ack_ok) begin
                        state <= ST_WAIT;
                     end else if (sub_read) begin
                        state <= ST_WAIT; // [RULE10]
                     end else begin
                        state <= ST_WHI;
                     end
                  end
                  ST_WHI: begin
                     wd_hi <= shreg;
                     sda_oe <= ack_ok;
                     drove_ack <= ack_ok;
                     state <= ack_ok ? ST_WLO : ST_WAIT;
                  end
                  ST_WLO: begin
                     sda_oe <= ack_ok;
                     drove_ack <= ack_ok;
                     wr_idx <= wr_hit[5:0];
                     wr_en <= ack_ok & wr_hit[6];
                     wr_data <= {wd_hi, shreg};
                     state <= ST_WAIT;
                  end
                  default: begin
                     state <= ST_WAIT;
                  end
               endcase
            end
         end else if (state == ST_WAIT && scl_fall && ack_phase) begin
            // close the last ack slot, then ignore the bus until start or stop
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
            if (drove_ack && ctrl_busy) begin
               scl_oe <= 1'b1; // [RULE11]
               stall_cnt <= 22'h000000;
            end
         end
      end
   end

   // ----------------------------------------
   // register bank with staged update
   // ----------------------------------------
   // each entry holds a pending copy, readable over the bus, and an active
   // copy seen by the datapath; staging keeps a half-written setup from
   // reaching the picture mid line or mid field
   genvar gi;
   generate
      for (gi = 0; gi < `DRP_NUM_REGS; gi = gi + 1) begin : g_reg
         reg [15:0] pend;
         reg [15:0] act;
         wire sel;
         assign sel = wr_en && (wr_idx == gi);
         always @(posedge clock) begin
            if (rst) begin
               pend <= (gi == 0) ? FW_VERSION : 16'h0000;
               act <= (gi == 0) ? FW_VERSION : 16'h0000;
            end else if (gi == 0) begin
               pend <= FW_VERSION; // [RULE6]
               act <= FW_VERSION;
            end else if (gi == 1) begin
               if (sel) begin
                  pend <= wr_data;
                  act <= wr_data; // [RULE7]
               end
            end else if (gi == 48 || gi == 49) begin
               if (sel) begin
                  pend <= wr_data;
               end
               if (line_start) begin
                  act <= pend; // [RULE9]
               end
            end else begin
               if (sel) begin
                  pend <= wr_data;
               end
               if (field_start) begin
                  act <= pend; // [RULE8]
               end
            end
         end
         assign pend_flat[gi*16 +: 16] = pend;
         assign active_regs[gi*16 +: 16] = act;
      end
   endgenerate

endmodule

// File: drp_map.vh
// constants for the display controller register read port
// Operation
// [RULE1] start, write address, subaddress, each acknowledged
// [RULE2] host writes direction 0, opens with start
// [RULE3] device acknowledges by pulling data low
// [RULE4] host ends low byte with nak, stop
// [RULE5] device naks acknowledge slots when in error
// [RULE6] version register 0x20 read only, always readable; the code naks reads of it like any access while in error
// [RULE7] immediate registers take writes at once
// [RULE8] vertical registers apply at next field
// [RULE9] horizontal registers apply at next line
// [RULE10] repeated start, read address, two bytes high first
// [RULE11] hold clock low while controller busy, bounded
// [RULE12] unused bits written and read as zero
// [RULE13] read subaddress value is hex 13
// [RULE14] two address bytes form index, high first
`ifndef DRP_MAP_VH
`define DRP_MAP_VH

// ----------------------------------------
// bus identity and subaddresses
// ----------------------------------------
`define DRP_DEV_ADDR 7'h45
`define DRP_SUB_READ 8'h13
`define DRP_SUB_WRITE 8'h12

// ----------------------------------------
// register bank shape and update classes
// ----------------------------------------
`define DRP_NUM_REGS 50
`define DRP_IDX_HORZ_B 6'h30
`define DRP_IDX_HORZ_C 6'h31

// ----------------------------------------
// stall timing
// ----------------------------------------
`define DRP_STALL_CYC 22'd2500000 // 20 ms of 8 ns clock cycles

// ----------------------------------------
// register addresses
// ----------------------------------------
`define DRP_A_FIRMWARE_VERSION 16'h0020
`define DRP_A_BEAM_CURRENT_CTRL 16'h0059
`define DRP_A_RED_CUTOFF_LEVEL 16'h006b
`define DRP_A_GREEN_CUTOFF_LEVEL 16'h006c
`define DRP_A_BLUE_CUTOFF_LEVEL 16'h006d
`define DRP_A_RED_WHITE_DRIVE 16'h006e
`define DRP_A_GREEN_WHITE_DRIVE 16'h006f
`define DRP_A_BLUE_WHITE_DRIVE 16'h0070
`define DRP_A_ANALOG_MEAS_CTRL 16'h0116
`define DRP_A_RED_CHANNEL_CTRL 16'h0117
`define DRP_A_GREEN_CHANNEL_CTRL 16'h011f
`define DRP_A_BLUE_CHANNEL_CTRL 16'h0127
`define DRP_A_SCALER_MODE_SELECT 16'h0131
`define DRP_A_LINE_FIFO_ACTIVE_LENGTH 16'h0132
`define DRP_A_COMPRESS_SCALER_COEFF 16'h0133
`define DRP_A_EXPAND_SCALER_COEFF 16'h0134
`define DRP_A_NONLINEAR_SCALING_COEFF 16'h0135
`define DRP_A_SCALER_A_WINDOW_1 16'h0136
`define DRP_A_SCALER_A_WINDOW_2 16'h0137
`define DRP_A_SCALER_A_WINDOW_3 16'h0138
`define DRP_A_SCALER_A_WINDOW_4 16'h0139
`define DRP_A_SCALER_A_WINDOW_5 16'h013a
`define DRP_A_SCALER_B_WINDOW_1 16'h013b
`define DRP_A_SCALER_B_WINDOW_2 16'h013c
`define DRP_A_SCALER_B_WINDOW_3 16'h013d
`define DRP_A_SCALER_B_WINDOW_4 16'h013e
`define DRP_A_SCALER_B_WINDOW_5 16'h013f
`define DRP_A_LUMA_TRANSIENT_CTRL 16'h014a
`define DRP_A_LUMA_FILTER_SELECT 16'h014b
`define DRP_A_LUMA_TRANSIENT_MIX_A 16'h014e
`define DRP_A_BLUE_TONE_CURVE 16'h014f
`define DRP_A_LUMA_TRANSIENT_MIX_B 16'h0152
`define DRP_A_GREEN_TONE_CURVE 16'h0153
`define DRP_A_PICTURE_FRAME_GEN_CTRL 16'h0154
`define DRP_A_RED_TONE_CURVE 16'h0157
`define DRP_A_PEAKING_BAND_CTRL 16'h0158
`define DRP_A_BRIGHTNESS_MODE 16'h015a
`define DRP_A_VELOCITY_MOD_CTRL_B 16'h015b
`define DRP_A_TRANSIENT_LIMIT 16'h015c
`define DRP_A_VELOCITY_MOD_LIMIT 16'h015f
`define DRP_A_VERTICAL_BLANK_STOP 16'h0160
`define DRP_A_VERTICAL_BLANK_START 16'h0164
`define DRP_A_VELOCITY_MOD_CTRL_A 16'h0167
`define DRP_A_FRAME_GEN_VERTICAL_END 16'h0168
`define DRP_A_PEAKING_CTRL_A 16'h016a
`define DRP_A_CHROMA_TRANSIENT_CTRL 16'h016b
`define DRP_A_FRAME_GEN_VERTICAL_BEGIN 16'h016c
`define DRP_A_PEAKING_CTRL_B 16'h016e
`define DRP_A_DEFLECTION_PARAM_B 16'h0183
`define DRP_A_DEFLECTION_PARAM_C 16'h0185

`endif

// File: drp_props.sv
// concurrent checks on the pins of the register read port
`timescale 1ns/1ps
`include "drp_map.vh"
module drp_props #(
   parameter [15:0] FW_VERSION = 16'h0001, // arbitrary value
   parameter [21:0] STALL_CYC = 22'd200
)(
   input wire clock,
   input wire rst,
   input wire scl_in,
   input wire scl_out,
   input wire scl_oe,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire ctrl_busy,
   input wire err_state,
   input wire line_start,
   input wire field_start,
   input wire [`DRP_NUM_REGS*16-1:0] active_regs
);
   reg [21:0] stall_len;
   // length of the current clock stretch, so a stuck hold shows up
   always @(posedge clock) begin
      if (rst || !scl_oe)
         stall_len <= 22'd0;
      else
         stall_len <= stall_len + 22'd1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("pin value not low");
   chk_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data moved while clock high");
   chk_ack_width: assert property ($rose(sda_oe) |-> sda_oe[*8])
      else $error("data drive too short");
   chk_err_nak: assert property (err_state && $past(err_state) |-> !$rose(sda_oe))
      else $error("acknowledge while in error");
   chk_version_fixed: assert property (active_regs[15:0] == FW_VERSION)
      else $error("version entry changed");
   chk_imm_on_ack: assert property ($changed(active_regs[31:16]) |-> sda_oe)
      else $error("immediate entry moved outside write ack");
   chk_vert_field: assert property (active_regs[767:32] != $past(active_regs[767:32])
      |-> $past(field_start)) else $error("field entry moved off field edge");
   chk_horz_line: assert property (active_regs[799:768] != $past(active_regs[799:768])
      |-> $past(line_start)) else $error("line entry moved off line edge");
   chk_stall_cause: assert property ($rose(scl_oe) |-> ctrl_busy || $past(ctrl_busy))
      else $error("stretch without busy");
   chk_stall_free: assert property (scl_oe && !ctrl_busy |-> ##[1:3] !scl_oe)
      else $error("stretch held after busy dropped");
   chk_stall_limit: assert property (stall_len <= STALL_CYC + 22'd2)
      else $error("stretch too long");
endmodule
bind drp_register_port drp_props #(.FW_VERSION(FW_VERSION), .STALL_CYC(STALL_CYC)) props_u (
   .clock(clock), .rst(rst), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl_busy(ctrl_busy),
   .err_state(err_state), .line_start(line_start), .field_start(field_start),
   .active_regs(active_regs));

// File: drp_host.sv
// bus host model on the open-drain clock and data lines
`timescale 1ns/1ps
`include "drp_map.vh"
module drp_host (
   input wire scl,
   input wire sda,
   output reg scl_low,
   output reg sda_low
);
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // release clock and wait out a stretch, bounded so a stuck line cannot hang us
   task clk_high;
      integer n;
      begin
         scl_low = 1'b0;
         n = 0;
         while (scl !== 1'b1 && n < 40000) begin
            #8;
            n = n + 1;
         end
         #40;
      end
   endtask
   task put_bit(input b, output r);
      begin
         #40;
         sda_low = ~b;
         #40;
         clk_high;
         r = sda;
         #40;
         scl_low = 1'b1;
      end
   endtask
   // start also serves as repeated start from clock low
   task start;
      begin
         #40;
         sda_low = 1'b0;
         clk_high;
         sda_low = 1'b1;
         #80;
         scl_low = 1'b1;
      end
   endtask
   task stop;
      begin
         #40;
         sda_low = 1'b1;
         #40;
         clk_high;
         sda_low = 1'b0;
         #80;
      end
   endtask
   task send(input [7:0] v, output nak);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1)
            put_bit(v[i], r);
         put_bit(1'b1, nak);
      end
   endtask
   // host acks the high byte and naks the low one
   task recv(input last, output [7:0] v);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            put_bit(1'b1, r);
            v[i] = r;
         end
         put_bit(last, r);
      end
   endtask
   // address phase, dropped at the first nak as a failed transfer
   task head(input [7:0] sub, input [15:0] a, output nak);
      reg [31:0] q;
      integer k;
      begin
         q = {`DRP_DEV_ADDR, 1'b0, sub, a};
         nak = 1'b0;
         start;
         for (k = 0; k < 4 && !nak; k = k + 1)
            send(q[31-8*k -: 8], nak);
      end
   endtask
   task write_reg(input [15:0] a, input [15:0] d, output nak);
      begin
         head(`DRP_SUB_WRITE, a, nak);
         if (!nak)
            send(d[15:8], nak);
         if (!nak)
            send(d[7:0], nak);
         stop;
      end
   endtask
   task read_reg(input [15:0] a, output [15:0] d, output nak);
      begin
         d = 16'h0000;
         head(`DRP_SUB_READ, a, nak);
         if (!nak) begin
            start;
            send({`DRP_DEV_ADDR, 1'b1}, nak);
         end
         if (!nak) begin
            recv(1'b0, d[15:8]);
            recv(1'b1, d[7:0]);
         end
         stop;
      end
   endtask
endmodule

// File: display_ctrl_register_read_port_test.sv
// self-checking bench for the register read port
`timescale 1ns/1ps
`include "drp_map.vh"
module display_ctrl_register_read_port_test;
   localparam [15:0] FW = 16'h5a3c; // arbitrary value
   reg clock, rst, ctrl_busy, err_state, line_start, field_start, nak;
   wire scl_low, sda_low, scl_out, scl_oe, sda_out, sda_oe;
   wire scl = ~(scl_low | scl_oe);
   wire sda = ~(sda_low | sda_oe);
   wire [`DRP_NUM_REGS*16-1:0] active_regs;
   integer n_mismatch, check_count, cyc, i;
   reg [15:0] rd;
   reg [47:0] rows [0:5]; // address, data, entry, class 0 imm 1 field 2 line
   drp_register_port #(.FW_VERSION(FW), .STALL_CYC(22'd200)) dut_u (
      .clock(clock), .rst(rst), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .ctrl_busy(ctrl_busy),
      .err_state(err_state), .line_start(line_start), .field_start(field_start),
      .active_regs(active_regs));
   drp_host host_u (.scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   function [15:0] ent(input integer k);
      ent = active_regs[k*16 +: 16];
   endfunction
   task tick(input integer n);
      begin
         repeat (n) @(posedge clock);
         #1;
      end
   endtask
   task check(input [95:0] what, input [15:0] exp, input [15:0] got);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // one-cycle boundary strobe: field when f is set, line otherwise
   task pulse(input f);
      begin
         tick(1);
         if (f)
            field_start = 1'b1;
         else
            line_start = 1'b1;
         tick(1);
         field_start = 1'b0;
         line_start = 1'b0;
         tick(2);
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", check_count, n_mismatch);
         if (n_mismatch == 0 && check_count > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // cycle ceiling: the whole run needs about 20000 cycles
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 80000) begin
         n_mismatch = n_mismatch + 1;
         end_of_test;
      end
   end
   initial begin
      rst = 1'b1;
      ctrl_busy = 1'b0;
      err_state = 1'b0;
      line_start = 1'b0;
      field_start = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      cyc = 0;
      rows[0] = {16'h0059, 16'ha5c3, 8'd1, 8'd0};
      rows[1] = {16'h0134, 16'h02aa, 8'd15, 8'd1};
      rows[2] = {16'h006b, 16'h0fff, 8'd2, 8'd1};
      rows[3] = {16'h016e, 16'h0123, 8'd47, 8'd1};
      rows[4] = {16'h0183, 16'h8001, 8'd48, 8'd2};
      rows[5] = {16'h0185, 16'h7ffe, 8'd49, 8'd2};
      tick(6);
      rst = 1'b0;
      tick(3);
      check("version", FW, ent(0));
      for (i = 1; i < `DRP_NUM_REGS; i = i + 1)
         check("reset entry", 16'h0000, ent(i));
      // write, hold staged entries on the wrong boundary, apply on the right one, read back
      for (i = 0; i < 6; i = i + 1) begin
         host_u.write_reg(rows[i][47:32], rows[i][31:16], nak);
         check("write ack", 16'h0000, {15'h0, nak});
         tick(4);
         if (rows[i][7:0] == 8'd0)
            check("immediate", rows[i][31:16], ent(rows[i][15:8]));
         else begin
            check("pending", 16'h0000, ent(rows[i][15:8]));
            pulse(rows[i][7:0] == 8'd2);
            check("wrong edge", 16'h0000, ent(rows[i][15:8]));
            pulse(rows[i][7:0] == 8'd1);
            check("applied", rows[i][31:16], ent(rows[i][15:8]));
         end
         host_u.read_reg(rows[i][47:32], rd, nak);
         check("read ack", 16'h0000, {15'h0, nak});
         check("read data", rows[i][31:16], rd);
      end
      // version is read-only: the write is acked and ignored
      host_u.write_reg(`DRP_A_FIRMWARE_VERSION, 16'hffff, nak);
      check("ro ack", 16'h0000, {15'h0, nak});
      host_u.read_reg(`DRP_A_FIRMWARE_VERSION, rd, nak);
      check("ro read", FW, rd);
      // error state naks the device address and leaves registers alone
      tick(1);
      err_state = 1'b1;
      host_u.write_reg(16'h0059, 16'h1111, nak);
      check("error nak", 16'h0001, {15'h0, nak});
      tick(1);
      err_state = 1'b0;
      check("error keep", 16'ha5c3, ent(1));
      // controller busy: clock is held low until busy drops
      ctrl_busy = 1'b1;
      fork
         host_u.read_reg(16'h0134, rd, nak);
         begin
            i = 0;
            while (scl_oe !== 1'b1 && i < 3000) begin
               tick(1);
               i = i + 1;
            end
            check("stretch", 16'h0000, {15'h0, scl});
            tick(100);
            ctrl_busy = 1'b0;
         end
      join
      check("stall ack", 16'h0000, {15'h0, nak});
      check("stall data", 16'h02aa, rd);
      end_of_test;
   end
endmodule
